// ==== core/lars_map.svh ====
// constants for the linear array readout sequencer
`ifndef LARS_MAP_SVH
`define LARS_MAP_SVH
`define LARS_NUM_PIXELS     64
`define LARS_END_EDGE       65
`define LARS_RESTART_EDGE   66
`define LARS_SAMPLE_W       8
`define LARS_CLK_DIV        5
`endif

// ==== core/lars_pkg.sv ====
// types shared by both ends of the readout link
package lars_pkg;
	typedef logic [7:0] lars_sample_t;
	typedef enum logic [1:0] {
		LARS_IDLE,
		LARS_START,
		LARS_READ,
		LARS_GAP
	} lars_ctl_e;
endpackage : lars_pkg

// ==== core/lars_link_if.sv ====
// link between the sensor array end and its controller end
`timescale 1ns/1ps
`include "lars_map.svh"
interface lars_link_if;
	logic                          link_clk_en;   // one-cycle pixel clock enable
	logic                          start_bit;     // start token input
	logic [`LARS_SAMPLE_W-1:0]     analog_pixel_output; // driven sample
	logic                          out_oe_n;      // low while output driven
	modport sensor (input link_clk_en, input start_bit,
		output analog_pixel_output, output out_oe_n);
	modport ctrl (output link_clk_en, output start_bit,
		input analog_pixel_output, input out_oe_n);
endinterface : lars_link_if

// ==== core/lars_pixel_cell.sv ====
// one pixel: integrator with a held sample
`timescale 1ns/1ps
`include "lars_map.svh"
module lars_pixel_cell
	import lars_pkg::*;
#(
	parameter int W = `LARS_SAMPLE_W
) (
	input  wire logic         clk,        // system clock
	input  wire logic         rst,        // sync reset
	input  wire logic         step,       // pixel clock enable
	input  wire logic [W-1:0] light,      // photocurrent per step
	input  wire logic         capture,    // common sample instant
	input  wire logic         clear_int,  // integrator reset
	output logic      [W-1:0] held        // held sample
);
	logic [W-1:0] integ_r;

	always_ff @(posedge clk) begin
		if (rst) begin
			integ_r <= '0;
		end else if (step) begin
			if (clear_int) begin
				integ_r <= '0; // RL4
			end else if (integ_r > ~light) begin
				integ_r <= '1; // saturate rather than wrap
			end else begin
				integ_r <= integ_r + light;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			held <= '0;
		end else if (step && capture) begin
			held <= integ_r; // RL11
		end
	end
endmodule : lars_pixel_cell

// ==== core/lars_sensor.sv ====
// sensor array end: token shift register, pixel cells, output switch
//
// Behaviour
// [RL1] start high over one edge starts readout
// [RL2] 64-bit register walks token one per edge
// [RL3] pixels presented on output one per edge
// [RL4] integrator reset when its bit clears
// [RL5] 65th edge drops token, output released
// [RL6] controller must give the 65th edge
// [RL7] next start no earlier than 66th edge
// [RL8] controller drops start before next edge
// [RL9] exposure equals spacing between start pulses
// [RL10] output released whenever no readout runs
// [RL11] all pixels sampled at one instant
// [RL12] controller pairs edge n with pixel n
`timescale 1ns/1ps
`include "lars_map.svh"
module lars_sensor
	import lars_pkg::*;
#(
	parameter int NPIX = `LARS_NUM_PIXELS,
	parameter int W    = `LARS_SAMPLE_W
) (
	input  wire logic              SYS_CLK,   // 25 MHz clock
	input  wire logic              SYS_RST,   // sync reset, high
	lars_link_if.sensor            LINK,      // link to controller
	input  wire logic [NPIX*W-1:0] LIGHT_IN   // per-pixel light level
);
	// ------------------------------------------------------------
	// token shift register
	// ------------------------------------------------------------
	logic [NPIX-1:0] token_r;
	logic [NPIX-1:0] token_nxt;
	logic            step;
	logic            capture;

	assign step      = LINK.link_clk_en;
	assign token_nxt = {token_r[NPIX-2:0], LINK.start_bit}; // RL1
	// sampling on the capturing edge makes every pixel share one stop instant
	assign capture   = LINK.start_bit; // RL9

	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			token_r <= '0;
		end else if (step) begin
			token_r <= token_nxt; // RL2 RL5
		end
	end

	// ------------------------------------------------------------
	// pixel cells
	// ------------------------------------------------------------
	logic [W-1:0] held [NPIX];

	for (genvar i = 0; i < NPIX; i++) begin : g_pix
		lars_pixel_cell #(.W(W)) u_cell (
			.clk       (SYS_CLK),
			.rst       (SYS_RST),
			.step      (step),
			.light     (LIGHT_IN[i*W +: W]),
			.capture   (capture),
			.clear_int (token_r[i] && !token_nxt[i]), // RL4
			.held      (held[i])
		);
	end

	// ------------------------------------------------------------
	// output switch
	// ------------------------------------------------------------
	logic [W-1:0] out_r;
	logic         oe_n_r;

	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			out_r  <= '0;
			oe_n_r <= 1'b1;
		end else begin
			out_r  <= '0;
			oe_n_r <= 1'b1; // RL10
			for (int i = 0; i < NPIX; i++) begin
				if (token_r[i]) begin
					out_r  <= held[i]; // RL3
					oe_n_r <= 1'b0;
				end
			end
		end
	end

	assign LINK.analog_pixel_output = out_r;
	assign LINK.out_oe_n            = oe_n_r; // RL5
endmodule : lars_sensor

// ==== core/lars_ctrl.sv ====
// controller end: pixel clock divider, start pulse, pixel collection
`timescale 1ns/1ps
`include "lars_map.svh"
module lars_ctrl
	import lars_pkg::*;
#(
	parameter int DIV = `LARS_CLK_DIV,
	parameter int W   = `LARS_SAMPLE_W
) (
	input  wire logic          SYS_CLK,     // 25 MHz clock
	input  wire logic          SYS_RST,     // sync reset, high
	lars_link_if.ctrl          LINK,        // link to sensor
	input  wire logic          FRAME_REQ,   // level: start a readout
	input  wire logic [15:0]   GAP_EDGES,   // extra idle edges, sets exposure
	output logic               PIX_VALID,   // one-cycle pixel strobe
	output logic [5:0]         PIX_INDEX,   // pixel number minus one
	output logic [W-1:0]       PIX_DATA,    // pixel sample
	output logic               FRAME_DONE   // one-cycle end of frame
);
	// ------------------------------------------------------------
	// pixel clock divider
	// ------------------------------------------------------------
	logic [7:0] div_r;
	logic       tick;

	assign tick = (div_r == 8'(DIV - 1));

	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST || tick) begin
			div_r <= 8'h00;
		end else begin
			div_r <= div_r + 8'h01;
		end
	end

	assign LINK.link_clk_en = tick;

	// ------------------------------------------------------------
	// sequence
	// ------------------------------------------------------------
	lars_ctl_e  st_r;
	logic [15:0] edge_r;
	logic        start_r;

	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			st_r    <= LARS_IDLE;
			edge_r  <= 16'h0000;
			start_r <= 1'b0;
		end else if (tick) begin
			case (st_r)
			LARS_IDLE: begin
				if (FRAME_REQ) begin
					start_r <= 1'b1;
					st_r    <= LARS_START;
				end
			end
			LARS_START: begin
				start_r <= 1'b0; // RL1 RL8
				edge_r  <= 16'h0001;
				st_r    <= LARS_READ;
			end
			LARS_READ: begin
				edge_r <= edge_r + 16'h0001;
				if (edge_r == 16'(`LARS_END_EDGE - 1)) begin
					st_r   <= LARS_GAP; // RL6
					edge_r <= 16'h0000;
				end
			end
			LARS_GAP: begin
				edge_r <= edge_r + 16'h0001;
				// at least one edge past the 65th before a new start
				if (edge_r >= GAP_EDGES) begin
					st_r <= LARS_IDLE; // RL7 RL9
				end
			end
			default: st_r <= LARS_IDLE;
			endcase
		end
	end

	assign LINK.start_bit = start_r;

	// ------------------------------------------------------------
	// collection: output after edge n belongs to pixel n
	// ------------------------------------------------------------
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			PIX_VALID  <= 1'b0;
			PIX_INDEX  <= 6'h00;
			PIX_DATA   <= '0;
			FRAME_DONE <= 1'b0;
		end else begin
			// sample one cycle before the next tick so the output has settled
			PIX_VALID  <= (div_r == 8'(DIV - 2)) && st_r == LARS_READ
				&& !LINK.out_oe_n; // RL12
			PIX_INDEX  <= 6'(edge_r - 16'h0001);
			PIX_DATA   <= LINK.analog_pixel_output;
			FRAME_DONE <= tick && st_r == LARS_READ
				&& edge_r == 16'(`LARS_END_EDGE - 1);
		end
	end
endmodule : lars_ctrl

// ==== test/lars_link_assertions.sv ====
// concurrent checks on the sensor-controller link
`timescale 1ns/1ps
module lars_link_assertions (
	input wire logic       SYS_CLK,             // clock
	input wire logic       SYS_RST,             // sync reset
	input wire logic       link_clk_en,         // pixel tick
	input wire logic       start_bit,           // start token
	input wire logic [7:0] analog_pixel_output, // sample
	input wire logic       out_oe_n             // low while driven
);
	// ticks since capture, 0 when idle; wraps on the 65th tick
	logic [6:0] cnt_r;
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST)
			cnt_r <= 7'h00;
		else if (link_clk_en && start_bit)
			cnt_r <= 7'h01;
		else if (link_clk_en && cnt_r != 7'h00)
			cnt_r <= (cnt_r == 7'h40) ? 7'h00 : cnt_r + 7'h01;
	end
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (SYS_RST);
	a_start_on_tick: assert property ($rose(start_bit) |-> ##[0:5] (start_bit && link_clk_en))
		else $error("start not taken on a tick");
	a_start_one_tick: assert property (start_bit && link_clk_en |=> !start_bit)
		else $error("start held past capture");
	// the output switch is registered behind the token, so the enable lags the count by one cycle
	a_oe_after_capture: assert property (start_bit && link_clk_en |-> ##2 !out_oe_n)
		else $error("output not driven after capture");
	a_oe_while_read: assert property (cnt_r != 7'h00 |=> !out_oe_n)
		else $error("output released mid readout");
	a_end_release: assert property (link_clk_en && cnt_r == 7'h40 |-> ##2 out_oe_n)
		else $error("output not released on 65th tick");
	a_idle_released: assert property (cnt_r == 7'h00 |=> out_oe_n)
		else $error("output driven while idle");
	a_restart_gap: assert property (start_bit && link_clk_en |-> cnt_r == 7'h00)
		else $error("start during readout");
	a_sample_on_tick: assert property ($changed(analog_pixel_output) |-> $past(link_clk_en, 2))
		else $error("sample moved off tick");
endmodule : lars_link_assertions

// ==== test/tb_linear_array_readout_sequencer.sv ====
// self-checking bench: controller and sensor joined over the link
`timescale 1ns/1ps
module tb_linear_array_readout_sequencer;
	import lars_pkg::*;
	logic         sys_clk = 1'b0;
	logic         sys_rst, frame_req, pix_valid, frame_done, chk;
	logic [15:0]  gap_edges;
	logic [511:0] light_in;
	logic [5:0]   pix_index;
	lars_sample_t pix_data;
	logic [63:0]  mask;
	int           n_fail, n_compared, n_pix;
	// rows: lit pixels and idle gap
	logic [63:0]  masks [4] = '{64'hffff_ffff_ffff_ffff, 64'h0, 64'haaaa_aaaa_aaaa_aaaa,
		64'h8000_0000_0000_0001};
	logic [15:0]  gaps [4] = '{16'h0000, 16'h0003, 16'h0001, 16'h000a};
	lars_link_if link ();
	lars_sensor u_lars_sensor (.SYS_CLK(sys_clk), .SYS_RST(sys_rst), .LINK(link),
		.LIGHT_IN(light_in));
	lars_ctrl u_lars_ctrl (.SYS_CLK(sys_clk), .SYS_RST(sys_rst), .LINK(link),
		.FRAME_REQ(frame_req), .GAP_EDGES(gap_edges), .PIX_VALID(pix_valid),
		.PIX_INDEX(pix_index), .PIX_DATA(pix_data), .FRAME_DONE(frame_done));
	lars_link_assertions u_lars_link_assertions (.SYS_CLK(sys_clk), .SYS_RST(sys_rst),
		.link_clk_en(link.link_clk_en), .start_bit(link.start_bit),
		.analog_pixel_output(link.analog_pixel_output), .out_oe_n(link.out_oe_n));
	always #20 sys_clk = ~sys_clk;
	// full-scale light saturates in one tick, so expected samples are 00 or ff
	always_comb for (int i = 0; i < 64; i++) light_in[i*8+:8] = mask[i] ? 8'hff : 8'h00;
	task automatic fail(input string s);
		n_fail++;
		$display("MISMATCH %0t %s", $time, s);
	endtask : fail
	task automatic report_and_stop;
		$display("compared %0d mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : report_and_stop
	// ----------------------------------------------------------------
	// pixel monitor
	// ----------------------------------------------------------------
	always @(posedge sys_clk) if (chk && pix_valid === 1'b1) begin
		n_compared++;
		if (pix_index !== n_pix[5:0] || pix_data !== (mask[n_pix] ? 8'hff : 8'h00)) fail("pixel");
		n_pix++;
	end
	// the first frame after a light change is discarded: its integration straddles it
	task automatic frame(input logic check);
		int i;
		chk = check;
		n_pix = 0;
		i = 0;
		do begin
			@(posedge sys_clk);
			i++;
		end while (frame_done !== 1'b1 && i < 2000);
		if (i >= 2000) fail("frame timeout");
		n_compared++;
		if (check && n_pix !== 64) fail("pixel count");
	endtask : frame
	initial begin
		sys_rst = 1'b1;
		frame_req = 1'b0;
		gap_edges = 16'h0000;
		mask = 64'h0;
		chk = 1'b0;
		n_fail = 0;
		n_compared = 0;
		n_pix = 0;
		repeat (2) @(posedge sys_clk);
		sys_rst <= 1'b0;
		for (int r = 0; r < 4; r++) begin
			mask <= masks[r];
			gap_edges <= gaps[r];
			frame_req <= 1'b1;
			frame(1'b0);
			frame(1'b1);
			$display("row %0d done", r);
		end
		repeat (100) @(posedge sys_clk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		sys_rst <= 1'b0;
		@(posedge sys_clk);
		n_compared++;
		if (link.out_oe_n !== 1'b1 || pix_valid !== 1'b0) fail("reset mid frame");
		frame(1'b0);
		frame(1'b1);
		frame_req <= 1'b0;
		repeat (400) @(posedge sys_clk);
		n_compared++;
		if (link.out_oe_n !== 1'b1) fail("idle output driven");
		$display("reset and idle tests done");
		report_and_stop();
	end
	initial begin
		#800000;
		fail("watchdog");
		report_and_stop();
	end
endmodule : tb_linear_array_readout_sequencer
